// >>> bench/imas_checker.sv
// Checker: port timing of the memory access and security block.
// Bound to every imas_top; sees only its ports.
`default_nettype none
module imas_checker #(
  parameter logic [63:0] UNLOCK_KEY = 64'h0
) (
  input wire logic        CLK_I,
  input wire logic        RST_I,
  input wire logic        PM_REQ_I,
  input wire logic [31:0] PM_ADDR_I,
  input wire logic        PM_ACK_O,
  input wire logic        PM_STALL_O,
  input wire logic        DM_REQ_I,
  input wire logic        IO_REQ_I,
  input wire logic        IO_WE_I,
  input wire logic [31:0] IO_ADDR_I,
  input wire logic        IO_STALL_O,
  input wire logic        PERIPH_SEL_O,
  input wire logic        SECURE_EN_I,
  input wire logic [63:0] KEY_I,
  input wire logic        UNLOCKED_O,
  input wire logic        EXT_BOOT_EN_O,
  input wire logic        EMU_EN_O,
  input wire logic        SEC_VIOL_O
);
  // One domain: shared clock and reset
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  // Decode, grant and security relations
  periph_no_ack_a: assert property (
    PM_REQ_I && PM_ADDR_I <= 32'h0003FFFF |=> PERIPH_SEL_O && !PM_ACK_O)
    else $error("peripheral access acknowledged");
  pm_ack_cause_a: assert property (
    PM_ACK_O |-> $past(PM_REQ_I))
    else $error("ack without request");
  pm_stall_cause_a: assert property (
    PM_STALL_O |-> $past(DM_REQ_I) && !PM_ACK_O)
    else $error("stall without rival");
  io_stall_cause_a: assert property (
    IO_STALL_O |-> $past(PM_REQ_I || DM_REQ_I))
    else $error("io stall without core access");
  key_match_a: assert property (
    $rose(UNLOCKED_O) |-> KEY_I == UNLOCK_KEY)
    else $error("unlocked by wrong key");
  unlock_hold_a: assert property (
    UNLOCKED_O |=> UNLOCKED_O)
    else $error("unlock lost");
  locked_gates_a: assert property (
    (SECURE_EN_I && !UNLOCKED_O)[*5] |-> !EXT_BOOT_EN_O && !EMU_EN_O)
    else $error("gates open while locked");
  rom_guard_a: assert property (
    IO_REQ_I && !IO_WE_I && IO_ADDR_I[31:15] == 17'h00010 && !PM_REQ_I && !DM_REQ_I
    && !UNLOCKED_O && !EXT_BOOT_EN_O |=> SEC_VIOL_O)
    else $error("locked rom read not flagged");
endmodule
bind imas_top imas_checker #(.UNLOCK_KEY(UNLOCK_KEY)) chk_u (.*);
`default_nettype wire

// >>> bench/imas_req_model.sv
// Bus requester model: stands in for a core or I/O bus master.
// Holds a request until acknowledged; gives up after 16 edges.
`default_nettype none
module imas_req_model #(
  parameter int DW = 64
) (
  input  wire logic          CLK_I,
  output logic               req_o,
  output logic               we_o,
  output logic [31:0]        addr_o,
  output logic [DW-1:0]      wdata_o,
  input  wire logic [DW-1:0] rdata_i,
  input  wire logic          ack_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial
  begin
    {req_o, we_o, addr_o, wdata_o} = {(DW + 34){1'b0}};
  end
  // One transfer; n is edges to ack, 0 when never acked
  task automatic access(input logic w, input logic [31:0] a, input logic [DW-1:0] d,
                        output logic [DW-1:0] q, output int n);
    @(posedge CLK_I);
    #1;
    {req_o, we_o, addr_o, wdata_o} = {1'b1, w, a, d};
    n = 0;
    // Ack is sampled settled, just after the edge that launched it
    for (int i = 1; i <= 16 && n == 0; i++)
    begin
      @(posedge CLK_I);
      #1;
      if (ack_i === 1'b1)
        n = i;
    end
    // Released lines show the inverse, not a held value
    {req_o, we_o, addr_o, wdata_o} = {1'b0, ~w, ~a, ~d};
    // Read data lands one edge after the ack
    @(posedge CLK_I);
    #1;
    q = rdata_i;
  endtask
endmodule
`default_nettype wire

// >>> bench/test_internal_memory_access_security.sv
// Bench: three requester models drive the memory block; self-checking.
// Assumes a 4 ns clock and a synchronous active-high reset.
`default_nettype none
module test_internal_memory_access_security;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] KEY = 64'h5A5A00FF1234C3C3; // Arbitrary value
  localparam logic [63:0] PAT = 64'hA5C30F1E9B7D2468;
  logic        clk, rst, sec, kv, pr, pw, dr, dw, ir, iw, pk, dk, ik, unl, ext, emu;
  logic [31:0] pa, da, ia, iwd, ird, q3;
  logic [63:0] key, pwd, prd, dwd, drd, q, q2;
  int          fails = 0, compares = 0, cyc = 0, n, n2, n3;
  imas_top #(.UNLOCK_KEY(KEY)) dut_u (
    .CLK_I(clk), .RST_I(rst), .SECURE_EN_I(sec), .KEY_VALID_I(kv), .KEY_I(key),
    .PM_REQ_I(pr), .PM_WE_I(pw), .PM_ADDR_I(pa), .PM_WDATA_I(pwd), .PM_RDATA_O(prd),
    .PM_ACK_O(pk), .PM_STALL_O(), .DM_REQ_I(dr), .DM_WE_I(dw), .DM_ADDR_I(da),
    .DM_WDATA_I(dwd), .DM_RDATA_O(drd), .DM_ACK_O(dk), .DM_STALL_O(),
    .IO_REQ_I(ir), .IO_WE_I(iw), .IO_ADDR_I(ia), .IO_WDATA_I(iwd), .IO_RDATA_O(ird),
    .IO_ACK_O(ik), .IO_STALL_O(), .PERIPH_SEL_O(), .UNLOCKED_O(unl),
    .EXT_BOOT_EN_O(ext), .EMU_EN_O(emu), .SEC_VIOL_O());
  imas_req_model #(.DW(64)) pm_u (.CLK_I(clk), .req_o(pr), .we_o(pw), .addr_o(pa),
    .wdata_o(pwd), .rdata_i(prd), .ack_i(pk));
  imas_req_model #(.DW(64)) dm_u (.CLK_I(clk), .req_o(dr), .we_o(dw), .addr_o(da),
    .wdata_o(dwd), .rdata_i(drd), .ack_i(dk));
  imas_req_model #(.DW(32)) io_u (.CLK_I(clk), .req_o(ir), .we_o(iw), .addr_o(ia),
    .wdata_o(iwd), .rdata_i(ird), .ack_i(ik));
  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Write then read back at each word width; 64-bit first
  task automatic t_widths();
    logic [31:0] a [4] = '{32'h00130000, 32'h00099000, 32'h00098000, 32'h0004C000};
    logic [63:0] m [4] = '{64'h000000000000FFFF, 64'h0000FFFFFFFFFFFF,
                           64'h00000000FFFFFFFF, 64'hFFFFFFFFFFFFFFFF};
    for (int k = 3; k >= 0; k--)
    begin
      dm_u.access(1'b1, a[k], PAT + k, q, n);
      dm_u.access(1'b0, a[k], 64'h0, q, n);
      chk("dm width data", (PAT + k) & m[k], q & m[k]);
      chk("dm wait", 64'h1, n);
    end
    io_u.access(1'b1, 32'h000E0001, 32'h3C5A9671, q3, n);
    io_u.access(1'b0, 32'h000E0001, 32'h0, q3, n);
    chk("io data", 64'h3C5A9671, q3);
  endtask
  // Three requesters on three blocks in one cycle
  task automatic t_parallel();
    fork
      pm_u.access(1'b0, 32'h0004C000, 64'h0, q, n);
      dm_u.access(1'b0, 32'h0005C010, 64'h0, q2, n2);
      io_u.access(1'b0, 32'h000C0010, 32'h0, q3, n3);
    join
    chk("pm data", PAT, q);
    chk("three waits", 64'h3, n + n2 + n3);
  endtask
  // Same-block clashes are served in turn
  task automatic t_conflict();
    fork
      pm_u.access(1'b0, 32'h0004C020, 64'h0, q, n);
      dm_u.access(1'b0, 32'h0004C028, 64'h0, q2, n2);
    join
    chk("pm dm waits", 64'h3, n + n2);
    fork
      dm_u.access(1'b0, 32'h00060000, 64'h0, q2, n2);
      io_u.access(1'b0, 32'h000C0004, 32'h0, q3, n3);
    join
    chk("io wait", 64'h2, n3);
  endtask
  task automatic key_strobe();
    @(posedge clk);
    #1 kv = 1'b1;
    repeat (4) @(posedge clk);
    #1 kv = 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask
  // Lock by strap, refuse a wrong key, accept the right one
  task automatic t_secure();
    chk("boot open", 64'h1, ext);
    sec = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk("gates shut", 64'h0, {ext, emu});
    io_u.access(1'b0, 32'h00080000, 32'h0, q3, n);
    chk("rom read ack", 64'h1, n);
    key = ~KEY;
    key_strobe();
    chk("bad key", 64'h0, {unl, ext, emu});
    key = KEY;
    key_strobe();
    chk("good key", 64'h7, {unl, ext, emu});
  endtask
  // Reset, then scenarios in turn
  initial
  begin
    {rst, sec, kv, key} = {1'b1, 1'b0, 1'b0, 64'h0};
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    t_widths();
    t_parallel();
    t_conflict();
    pm_u.access(1'b0, 32'h00000100, 64'h0, q, n);
    chk("periph wait", 64'h0, n);
    t_secure();
    finish_test();
  end
endmodule
`default_nettype wire

// >>> hdl/imas_bank.v
// One memory block: single-cycle port shared by arbitration outcome.
// Assumes the caller presents at most one granted access per cycle.
`default_nettype none
module imas_bank #(
  parameter AW = 14,
  parameter DW = 64
) (
  input  wire          CLK_I,
  input  wire          we_i,
  input  wire          en_i,
  input  wire [AW-1:0] addr_i,
  input  wire [DW-1:0] wdata_i,
  input  wire [DW/8-1:0] be_i,
  output reg  [DW-1:0] rdata_o
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  integer      k;

  // Byte-lane write, registered read
  always @(posedge CLK_I)
  begin
    if (en_i)
    begin
      for (k = 0; k < DW/8; k = k + 1)
      begin
        if (we_i && be_i[k])
          mem[addr_i][k*8 +: 8] <= wdata_i[k*8 +: 8];
      end
      rdata_o <= mem[addr_i];
    end
  end
endmodule
`default_nettype wire

// >>> hdl/imas_defs.vh
// Constants for the internal memory access and security block.
// Assumes 32-bit word addresses on all three requester buses.
`ifndef IMAS_DEFS_VH
`define IMAS_DEFS_VH
// Peripheral register space upper bound
`define IMAS_PERIPH_TOP     32'h0003FFFF
// Long word (64-bit) range
`define IMAS_LW_LO          32'h00040000
`define IMAS_LW_HI          32'h0007FFFF
// Extended / instruction word range, decoded as 32-bit (IMAS_W32)
`define IMAS_EW_LO          32'h00080000
`define IMAS_EW_HI          32'h000FFFFF
// Short word (16-bit) range
`define IMAS_SW_LO          32'h00100000
`define IMAS_SW_HI          32'h001FFFFF
// Width codes
`define IMAS_W16            2'h0
`define IMAS_W32            2'h1
`define IMAS_W48            2'h2
`define IMAS_W64            2'h3
// Block select field positions per width
`define IMAS_LW_BLK_LSB     16
`define IMAS_NW_BLK_LSB     17
`define IMAS_SW_BLK_LSB     18
// ROM/SRAM split bit per width
`define IMAS_LW_RAM_BIT     14
`define IMAS_NW_RAM_BIT     15
`define IMAS_SW_RAM_BIT     16
// Key width
`define IMAS_KEY_W          64
`endif

// >>> hdl/imas_top.v
// Internal memory: four blocks, three requesters, ROM security gate.
// Assumes I/O bus already synchronous to CLK_I; key arrives from test port.
`include "imas_defs.vh"
`default_nettype none
module imas_top #(
  parameter AW = 14,
  parameter [`IMAS_KEY_W-1:0] UNLOCK_KEY = 64'h0123456789ABCDEF // Arbitrary value
) (
  input  wire                   CLK_I,
  input  wire                   RST_I,
  input  wire                   PM_REQ_I,
  input  wire                   PM_WE_I,
  input  wire [31:0]            PM_ADDR_I,
  input  wire [63:0]            PM_WDATA_I,
  output reg  [63:0]            PM_RDATA_O,
  output reg                    PM_ACK_O,
  output reg                    PM_STALL_O,
  input  wire                   DM_REQ_I,
  input  wire                   DM_WE_I,
  input  wire [31:0]            DM_ADDR_I,
  input  wire [63:0]            DM_WDATA_I,
  output reg  [63:0]            DM_RDATA_O,
  output reg                    DM_ACK_O,
  output reg                    DM_STALL_O,
  input  wire                   IO_REQ_I,
  input  wire                   IO_WE_I,
  input  wire [31:0]            IO_ADDR_I,
  input  wire [31:0]            IO_WDATA_I,
  output reg  [31:0]            IO_RDATA_O,
  output reg                    IO_ACK_O,
  output reg                    IO_STALL_O,
  output reg                    PERIPH_SEL_O,
  input  wire                   SECURE_EN_I,
  input  wire                   KEY_VALID_I,
  input  wire [`IMAS_KEY_W-1:0] KEY_I,
  output reg                    UNLOCKED_O,
  output reg                    EXT_BOOT_EN_O,
  output reg                    EMU_EN_O,
  output reg                    SEC_VIOL_O
);
  localparam NB = 4;

  // Synchronised strap and key strobe from pins
  reg sec_s1_q, sec_s2_q, kv_s1_q, kv_s2_q, kv_s3_q;
  reg locked_q;
  reg unlocked_q;

  // Decode: returns {hit, rom, width, block[1:0], index[AW-1:0]}
  function [AW+5:0] decode;
    input [31:0] a;
    reg          hit, rom;
    reg [1:0]    w, blk;
    reg [AW-1:0] idx;
    begin
      hit = 1'b0;
      rom = 1'b0;
      w   = `IMAS_W32;
      blk = 2'h0;
      idx = {AW{1'b0}};
      if (a <= `IMAS_PERIPH_TOP)
        hit = 1'b0;
      else if (a >= `IMAS_LW_LO && a <= `IMAS_LW_HI)
      begin
        hit = 1'b1;
        w   = `IMAS_W64;
        blk = a[`IMAS_LW_BLK_LSB +: 2];
        rom = (blk < 2'h2) && !a[`IMAS_LW_RAM_BIT];
        idx = a[AW-1:0];
      end
      else if (a >= `IMAS_EW_LO && a <= `IMAS_EW_HI)
      begin
        hit = 1'b1;
        w   = `IMAS_W32;
        blk = a[`IMAS_NW_BLK_LSB +: 2];
        rom = (blk < 2'h2) && !a[`IMAS_NW_RAM_BIT];
        idx = a[AW:1];
      end
      else if (a >= `IMAS_SW_LO && a <= `IMAS_SW_HI)
      begin
        hit = 1'b1;
        w   = `IMAS_W16;
        blk = a[`IMAS_SW_BLK_LSB +: 2];
        rom = (blk < 2'h2) && !a[`IMAS_SW_RAM_BIT];
        idx = a[AW+1:2];
      end
      decode = {hit, rom, w, blk, idx};
    end
  endfunction

  wire [AW+5:0] pm_dec = decode(PM_ADDR_I);
  wire [AW+5:0] dm_dec = decode(DM_ADDR_I);
  wire [AW+5:0] io_dec = decode(IO_ADDR_I);
  wire [1:0] pm_blk = pm_dec[AW+1:AW];
  wire [1:0] dm_blk = dm_dec[AW+1:AW];
  wire [1:0] io_blk = io_dec[AW+1:AW];
  wire pm_hit = PM_REQ_I && pm_dec[AW+5];
  wire dm_hit = DM_REQ_I && dm_dec[AW+5];
  wire io_hit = IO_REQ_I && io_dec[AW+5];

  // Secured reads of ROM from I/O side are refused
  wire io_block = locked_q && io_dec[AW+4] && !IO_WE_I;

  // Fixed priority with rotation on conflict: DM, PM, IO
  reg prio_q;
  wire pm_cfl_dm = pm_hit && dm_hit && (pm_blk == dm_blk);
  wire dm_go = dm_hit && !(pm_cfl_dm && prio_q);
  wire pm_go = pm_hit && !(pm_cfl_dm && !prio_q);
  wire io_go = io_hit && !io_block &&
               !(dm_go && dm_blk == io_blk) &&
               !(pm_go && pm_blk == io_blk);

  // Per-block steering
  wire [NB-1:0]    b_en;
  wire [NB-1:0]    b_we;
  wire [AW*NB-1:0] b_addr;
  wire [64*NB-1:0] b_wd;
  wire [8*NB-1:0]  b_be;
  wire [64*NB-1:0] b_rd;

  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1)
    begin : g_blk
      wire sd = dm_go && dm_blk == g;
      wire sp = pm_go && pm_blk == g;
      wire si = io_go && io_blk == g;
      // ROM halves of blocks 0 and 1 are not writable
      wire rom_hit = sd ? dm_dec[AW+4] : sp ? pm_dec[AW+4] : io_dec[AW+4];
      assign b_en[g] = sd | sp | si;
      assign b_we[g] = !rom_hit && (sd ? DM_WE_I : sp ? PM_WE_I : IO_WE_I);
      assign b_addr[g*AW +: AW] = sd ? dm_dec[AW-1:0] :
                                  sp ? pm_dec[AW-1:0] : io_dec[AW-1:0];
      assign b_wd[g*64 +: 64] = sd ? DM_WDATA_I : sp ? PM_WDATA_I :
                                {IO_WDATA_I, IO_WDATA_I};
      assign b_be[g*8 +: 8] = (sd | sp) ? 8'hFF :
                              (IO_ADDR_I[0] ? 8'hF0 : 8'h0F);
      imas_bank #(
        .AW (AW),
        .DW (64)
      ) u_bank (
        .CLK_I   (CLK_I),
        .we_i    (b_we[g]),
        .en_i    (b_en[g]),
        .addr_i  (b_addr[g*AW +: AW]),
        .wdata_i (b_wd[g*64 +: 64]),
        .be_i    (b_be[g*8 +: 8]),
        .rdata_o (b_rd[g*64 +: 64])
      );
    end
  endgenerate

  // Return-path selection, one cycle after the grant
  reg [1:0] pm_rb_q, dm_rb_q, io_rb_q;
  reg       io_hi_q;
  reg       pm_v_q, dm_v_q, io_v_q;
  wire [63:0] io_word = b_rd[io_rb_q*64 +: 64];

  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      pm_rb_q <= 2'h0;
      dm_rb_q <= 2'h0;
      io_rb_q <= 2'h0;
      io_hi_q <= 1'b0;
      pm_v_q  <= 1'b0;
      dm_v_q  <= 1'b0;
      io_v_q  <= 1'b0;
      prio_q  <= 1'b0;
    end
    else
    begin
      pm_rb_q <= pm_blk;
      dm_rb_q <= dm_blk;
      io_rb_q <= io_blk;
      io_hi_q <= IO_ADDR_I[0];
      pm_v_q  <= pm_go;
      dm_v_q  <= dm_go;
      io_v_q  <= io_go;
      // Alternate winner after each conflict
      if (pm_cfl_dm)
        prio_q <= !prio_q;
    end
  end

  // Registered handshake outputs
  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      PM_ACK_O     <= 1'b0;
      DM_ACK_O     <= 1'b0;
      IO_ACK_O     <= 1'b0;
      PM_STALL_O   <= 1'b0;
      DM_STALL_O   <= 1'b0;
      IO_STALL_O   <= 1'b0;
      PERIPH_SEL_O <= 1'b0;
      SEC_VIOL_O   <= 1'b0;
    end
    else
    begin
      PM_ACK_O     <= pm_go;
      DM_ACK_O     <= dm_go;
      IO_ACK_O     <= io_go || (IO_REQ_I && io_block);
      PM_STALL_O   <= pm_hit && !pm_go;
      DM_STALL_O   <= dm_hit && !dm_go;
      IO_STALL_O   <= io_hit && !io_go && !io_block;
      PERIPH_SEL_O <= (PM_REQ_I && PM_ADDR_I <= `IMAS_PERIPH_TOP) ||
                      (DM_REQ_I && DM_ADDR_I <= `IMAS_PERIPH_TOP) ||
                      (IO_REQ_I && IO_ADDR_I <= `IMAS_PERIPH_TOP);
      SEC_VIOL_O   <= IO_REQ_I && io_block;
    end
  end

  // Read data, one cycle after the ack edge
  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      PM_RDATA_O <= 64'h0000000000000000;
      DM_RDATA_O <= 64'h0000000000000000;
      IO_RDATA_O <= 32'h00000000;
    end
    else
    begin
      if (pm_v_q)
        PM_RDATA_O <= b_rd[pm_rb_q*64 +: 64];
      if (dm_v_q)
        DM_RDATA_O <= b_rd[dm_rb_q*64 +: 64];
      if (io_v_q)
        IO_RDATA_O <= io_hi_q ? io_word[63:32] : io_word[31:0];
    end
  end

  // Security: strap and key strobe synchronised, key compared once
  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      sec_s1_q   <= 1'b0;
      sec_s2_q   <= 1'b0;
      kv_s1_q    <= 1'b0;
      kv_s2_q    <= 1'b0;
      kv_s3_q    <= 1'b0;
      locked_q   <= 1'b1;
      unlocked_q <= 1'b0;
    end
    else
    begin
      sec_s1_q <= SECURE_EN_I;
      sec_s2_q <= sec_s1_q;
      kv_s1_q  <= KEY_VALID_I;
      kv_s2_q  <= kv_s1_q;
      kv_s3_q  <= kv_s2_q;
      if (kv_s2_q && !kv_s3_q && KEY_I == UNLOCK_KEY)
        unlocked_q <= 1'b1;
      // Wrong key leaves state unchanged
      locked_q <= sec_s2_q && !unlocked_q;
    end
  end

  // Gate outputs from the security state
  always @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      UNLOCKED_O    <= 1'b0;
      EXT_BOOT_EN_O <= 1'b0;
      EMU_EN_O      <= 1'b0;
    end
    else
    begin
      UNLOCKED_O    <= unlocked_q;
      EXT_BOOT_EN_O <= !locked_q;
      EMU_EN_O      <= !locked_q;
    end
  end
endmodule
`default_nettype wire
